// ### timer_channel_capture_pwm.sv
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
// Function
// [RULE1] Edge select 00 releases the pin.
// [RULE2] Mode 00 captures on selected edges.
// [RULE3] Mode 01 toggles, clears or sets on match.
// [RULE4] Mode 1X gives edge-aligned PWM.
// [RULE5] Center select forces center-aligned PWM everywhere.
// [RULE6] Reset clears both channel value bytes.
// [RULE7] Capture mode byte read latches other byte.
// [RULE8] Status/control write resets coherency latches.
// [RULE9] Value writes ignored in capture mode.
// [RULE10] Debug freezes read latch, returns live bytes.
// [RULE11] Compare/PWM writes buffer until both bytes.
// [RULE12] Clock off: transfer on second byte.
// [RULE13] Compare: transfer at next counter change.
// [RULE14] PWM: transfer at modulo minus one.
// [RULE15] Debug writes go straight to active register.
// [RULE16] One shared 16-bit counter with modulo.
// [RULE17] Center select makes counter count up/down.
// [RULE18] Clock source selects none, bus, fixed.
// [RULE19] Clock source resets to off.
// [RULE20] Stopping clock keeps all register contents.
// [RULE21] Source 11 uses synchronized channel pin.
// [RULE22] Flag on capture or match, not 0/100%.
// [RULE23] Pins synchronized before edge detection.
module timer_channel_capture_pwm (
  input  wire logic                                    clk_i,           // 250 MHz clock
  input  wire logic                                    nrst_i,          // sync reset, low
  input  wire logic [timer_pkg::ADDR_W-1:0]            address_i,       // byte address
  input  wire logic                                    read_i,          // read request
  input  wire logic                                    write_i,         // write request
  input  wire logic [31:0]                             writedata_i,     // write data
  input  wire logic [3:0]                              byteenable_i,    // byte lanes
  output logic      [31:0]                             readdata_o,      // read data
  output logic                                         waitrequest_o,   // stall, high
  input  wire logic                                    debug_active_i,  // background debug
  input  wire logic                                    fixed_tick_i,    // fixed clock enable
  input  wire logic [timer_pkg::NUM_CH-1:0]            ch_pin_i,        // channel pins in
  output logic      [timer_pkg::NUM_CH-1:0]            ch_pin_o,        // channel pins out
  output logic      [timer_pkg::NUM_CH-1:0]            ch_pin_oe_o      // pin drive enable
);

  localparam int N = timer_pkg::NUM_CH;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic timer_pkg::ch_mode_type decode_mode(input logic center_aligned_pwm,
                                                         input logic [1:0] ms);
    if (center_aligned_pwm)
      return timer_pkg::M_CENTER_ALIGNED_PWM;                                          // [RULE5]
    else if (ms[1])
      return timer_pkg::M_EDGE_ALIGNED_PWM;                                          // [RULE4]
    else if (ms[0])
      return timer_pkg::M_COMPARE;                                       // [RULE3]
    else
      return timer_pkg::M_CAPTURE;                                       // [RULE2]
  endfunction : decode_mode

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [7:0]  tsc_reg;
  logic [15:0] cnt_reg;
  logic        dir_up_reg;
  logic [15:0] mod_reg;
  logic [6:0]  presc_reg;
  logic [7:0]  sc_reg    [N];
  logic [15:0] val_reg   [N];
  logic [15:0] wbuf_reg  [N];
  logic [1:0]  wdone_reg [N];
  logic        pend_reg  [N];
  logic [1:0]  rstate_reg[N];
  logic [7:0]  rbuf_reg  [N];
  logic        arm_reg   [N];
  logic [N-1:0] sync1_reg;
  logic [N-1:0] sync2_reg;
  logic [N-1:0] sync3_reg;
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic [N-1:0] pin_reg;
  logic [N-1:0] oe_reg;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  logic        rd_go;
  logic        wr_go;
  logic [7:0]  ch_ofs [N];
  assign rd_go = read_i && wait_reg;
  assign wr_go = write_i && wait_reg && byteenable_i[0];

  always_comb
  begin
    for (int n = 0; n < N; n++)
      ch_ofs[n] = 8'(address_i - timer_pkg::OFS_CH_BASE - 8'(n) * timer_pkg::CH_STRIDE);
  end

  // ---------------------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------------------
  logic [1:0]  cs;
  logic        center_aligned_pwm;
  logic [15:0] term;
  logic        src_tick;
  logic        cnt_tick;
  logic [15:0] cnt_nx;
  logic        dir_nx;
  logic        wrap;
  logic        ext_rise;
  assign cs       = tsc_reg[timer_pkg::TSC_CS_LSB +: 2];
  assign center_aligned_pwm     = tsc_reg[timer_pkg::TSC_CENTER_ALIGNED_PWM_BIT];
  assign term     = (mod_reg == 16'h0000) ? timer_pkg::CNT_FREE_TOP : mod_reg;  // [RULE16]
  assign ext_rise = sync2_reg[0] && !sync3_reg[0];                        // [RULE21]

  always_comb
  begin
    unique case (cs)                                                     // [RULE18]
      timer_pkg::CS_OFF:   src_tick = 1'b0;
      timer_pkg::CS_BUS:   src_tick = 1'b1;
      timer_pkg::CS_FIXED: src_tick = fixed_tick_i;
      timer_pkg::CS_EXT:   src_tick = ext_rise;                          // [RULE21]
    endcase
  end

  // The counter is frozen while debug is active, so captures taken then latch a still value.
  assign cnt_tick = src_tick && !debug_active_i &&
                    (presc_reg == 7'((8'h01 << tsc_reg[timer_pkg::TSC_PS_LSB +: 3]) - 8'h01));

  always_comb
  begin
    dir_nx = dir_up_reg;
    wrap   = 1'b0;
    if (!center_aligned_pwm)
    begin
      dir_nx = 1'b1;
      if (cnt_reg == term)
      begin
        cnt_nx = 16'h0000;
        wrap   = 1'b1;
      end
      else
        cnt_nx = cnt_reg + 16'h0001;
    end
    else if (dir_up_reg)                                                 // [RULE17]
    begin
      if (cnt_reg == term)
      begin
        cnt_nx = cnt_reg - 16'h0001;
        dir_nx = 1'b0;
      end
      else
        cnt_nx = cnt_reg + 16'h0001;
    end
    else if (cnt_reg == 16'h0000)
    begin
      cnt_nx = 16'h0001;
      dir_nx = 1'b1;
    end
    else
      cnt_nx = cnt_reg - 16'h0001;
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      tsc_reg <= timer_pkg::TSC_RESET;                                   // [RULE19]
    else if (wr_go && hit(address_i, timer_pkg::OFS_TSC))
      tsc_reg <= {2'h0, writedata_i[5:0]};                               // [RULE20]
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      mod_reg <= 16'h0000;
    else if (wr_go && hit(address_i, timer_pkg::OFS_MOD) && byteenable_i[1])
      mod_reg <= writedata_i[15:0];
  end

  // Stopping the clock only halts these updates; no value is cleared.
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      cnt_reg    <= 16'h0000;
      dir_up_reg <= 1'b1;
      presc_reg  <= 7'h00;
    end
    else if (wr_go && hit(address_i, timer_pkg::OFS_CNT))
    begin
      cnt_reg    <= 16'h0000;
      dir_up_reg <= 1'b1;
      presc_reg  <= 7'h00;
    end
    else if (cnt_tick)                                                   // [RULE16]
    begin
      cnt_reg    <= cnt_nx;
      dir_up_reg <= dir_nx;
      presc_reg  <= 7'h00;
    end
    else if (src_tick && !debug_active_i)
      presc_reg  <= presc_reg + 7'h01;                                   // [RULE20]
  end

  // ---------------------------------------------------------------------------
  // Pin synchronizers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end
    else
    begin
      sync1_reg <= ch_pin_i;                                             // [RULE23]
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Channel events
  // ---------------------------------------------------------------------------
  timer_pkg::ch_mode_type mode [N];
  logic [1:0] els     [N];
  logic       cap_ev  [N];
  logic       match   [N];
  logic       flag_ev [N];

  always_comb
  begin
    for (int n = 0; n < N; n++)
    begin
      mode[n]    = decode_mode(center_aligned_pwm, sc_reg[n][timer_pkg::SC_MS_LSB +: 2]);
      els[n]     = sc_reg[n][timer_pkg::SC_ELS_LSB +: 2];
      cap_ev[n]  = (mode[n] == timer_pkg::M_CAPTURE) &&                  // [RULE2]
                   ((els[n][0] && sync2_reg[n] && !sync3_reg[n]) ||
                    (els[n][1] && !sync2_reg[n] && sync3_reg[n]));
      match[n]   = cnt_tick && (mode[n] != timer_pkg::M_CAPTURE) && (cnt_nx == val_reg[n]);
      flag_ev[n] = cap_ev[n] ||                                          // [RULE22]
                   (match[n] && ((mode[n] == timer_pkg::M_COMPARE) ||
                    ((val_reg[n] != 16'h0000) && (val_reg[n] <= term))));
    end
  end

  // ---------------------------------------------------------------------------
  // Channel status/control and flag clearing
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    for (int n = 0; n < N; n++)
    begin
      if (!nrst_i)
      begin
        sc_reg[n]  <= timer_pkg::SC_RESET;
        arm_reg[n] <= 1'b0;
      end
      else
      begin
        // A new event disarms the clear so a pending request is never lost.
        if (flag_ev[n])
          arm_reg[n] <= 1'b0;
        else if (rd_go && hit(ch_ofs[n], timer_pkg::OFS_CH_SC) &&
                 sc_reg[n][timer_pkg::SC_FLAG_BIT])
          arm_reg[n] <= 1'b1;
        else if (wr_go && hit(ch_ofs[n], timer_pkg::OFS_CH_SC))
          arm_reg[n] <= 1'b0;
        if (wr_go && hit(ch_ofs[n], timer_pkg::OFS_CH_SC))
          sc_reg[n][6:0] <= writedata_i[6:0];
        if (flag_ev[n])
          sc_reg[n][timer_pkg::SC_FLAG_BIT] <= 1'b1;                     // [RULE22]
        else if (wr_go && hit(ch_ofs[n], timer_pkg::OFS_CH_SC) && arm_reg[n] &&
                 !writedata_i[timer_pkg::SC_FLAG_BIT])
          sc_reg[n][timer_pkg::SC_FLAG_BIT] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Channel value registers and coherency latches
  // ---------------------------------------------------------------------------
  logic wr_hi [N];
  logic wr_lo [N];
  logic rd_hi [N];
  logic rd_lo [N];
  logic sc_wr [N];
  logic xfer  [N];

  always_comb
  begin
    for (int n = 0; n < N; n++)
    begin
      wr_hi[n] = wr_go && hit(ch_ofs[n], timer_pkg::OFS_CH_VH) &&
                 (mode[n] != timer_pkg::M_CAPTURE);                      // [RULE9]
      wr_lo[n] = wr_go && hit(ch_ofs[n], timer_pkg::OFS_CH_VL) &&
                 (mode[n] != timer_pkg::M_CAPTURE);                      // [RULE9]
      rd_hi[n] = rd_go && hit(ch_ofs[n], timer_pkg::OFS_CH_VH);
      rd_lo[n] = rd_go && hit(ch_ofs[n], timer_pkg::OFS_CH_VL);
      sc_wr[n] = wr_go && hit(ch_ofs[n], timer_pkg::OFS_CH_SC);
      if (cs == timer_pkg::CS_OFF)
        xfer[n] = 1'b1;                                                  // [RULE12]
      else if (mode[n] == timer_pkg::M_COMPARE)
        xfer[n] = cnt_tick;                                              // [RULE13]
      else
        xfer[n] = cnt_tick && dir_up_reg && (cnt_reg == term - 16'h0001); // [RULE14]
    end
  end

  always_ff @(posedge clk_i)
  begin
    for (int n = 0; n < N; n++)
    begin
      if (!nrst_i)
      begin
        val_reg[n]    <= timer_pkg::VAL_RESET;                           // [RULE6]
        wbuf_reg[n]   <= timer_pkg::VAL_RESET;
        wdone_reg[n]  <= 2'h0;
        pend_reg[n]   <= 1'b0;
        rstate_reg[n] <= 2'h0;
        rbuf_reg[n]   <= 8'h00;
      end
      else
      begin
        // Pending transfer first; debug writes below may still overwrite a byte.
        if (pend_reg[n] && xfer[n])
        begin
          val_reg[n]  <= wbuf_reg[n];                                    // [RULE11]
          pend_reg[n] <= 1'b0;
        end
        if (cap_ev[n])
          val_reg[n] <= cnt_reg;                                         // [RULE2]
        if (debug_active_i)
        begin
          if (wr_hi[n])
            val_reg[n][15:8] <= writedata_i[7:0];                        // [RULE15]
          if (wr_lo[n])
            val_reg[n][7:0]  <= writedata_i[7:0];                        // [RULE15]
        end
        else if (wr_hi[n] || wr_lo[n])
        begin
          if (wr_hi[n])
            wbuf_reg[n][15:8] <= writedata_i[7:0];                       // [RULE11]
          else
            wbuf_reg[n][7:0]  <= writedata_i[7:0];                       // [RULE11]
          if ((wdone_reg[n] | {wr_hi[n], wr_lo[n]}) == 2'h3)
          begin
            wdone_reg[n] <= 2'h0;
            if (cs == timer_pkg::CS_OFF)
            begin
              pend_reg[n] <= 1'b0;
              val_reg[n]  <= wr_hi[n] ? {writedata_i[7:0], wbuf_reg[n][7:0]}
                                      : {wbuf_reg[n][15:8], writedata_i[7:0]};  // [RULE12]
            end
            else
              pend_reg[n] <= 1'b1;                                       // [RULE11]
          end
          else
            wdone_reg[n] <= wdone_reg[n] | {wr_hi[n], wr_lo[n]};
        end
        // Read latch: 1 holds the low byte, 2 holds the high byte.
        if (sc_wr[n])
        begin
          wdone_reg[n]  <= 2'h0;                                         // [RULE8]
          rstate_reg[n] <= 2'h0;                                         // [RULE8]
        end
        else if (!debug_active_i && (mode[n] == timer_pkg::M_CAPTURE))  // [RULE10]
        begin
          if (rd_hi[n])
          begin
            rstate_reg[n] <= (rstate_reg[n] == 2'h2) ? 2'h0 : 2'h1;      // [RULE7]
            rbuf_reg[n]   <= val_reg[n][7:0];
          end
          else if (rd_lo[n])
          begin
            rstate_reg[n] <= (rstate_reg[n] == 2'h1) ? 2'h0 : 2'h2;      // [RULE7]
            rbuf_reg[n]   <= val_reg[n][15:8];
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Channel pins
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    for (int n = 0; n < N; n++)
    begin
      if (!nrst_i)
      begin
        pin_reg[n] <= 1'b0;
        oe_reg[n]  <= 1'b0;
      end
      else
      begin
        oe_reg[n] <= (els[n] != timer_pkg::ELS_OFF) &&                   // [RULE1]
                     (mode[n] != timer_pkg::M_CAPTURE);
        unique case (mode[n])
          timer_pkg::M_CAPTURE:
            pin_reg[n] <= 1'b0;
          timer_pkg::M_COMPARE:
            if (match[n])
              pin_reg[n] <= (els[n] == 2'h1) ? !pin_reg[n] : els[n][0];  // [RULE3]
          timer_pkg::M_EDGE_ALIGNED_PWM:
            if (match[n])
              pin_reg[n] <= els[n][0];                                   // [RULE4]
            else if (cnt_tick && wrap)
              pin_reg[n] <= !els[n][0];                                  // [RULE4]
          timer_pkg::M_CENTER_ALIGNED_PWM:
            if (cnt_tick)
              pin_reg[n] <= (cnt_nx < val_reg[n]) ^ els[n][0];           // [RULE5]
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Avalon-MM slave, one wait state on every access
  // ---------------------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit(address_i, timer_pkg::OFS_TSC))
      rd_mux = {24'h0, tsc_reg};
    else if (hit(address_i, timer_pkg::OFS_CNT))
      rd_mux = {16'h0, cnt_reg};
    else if (hit(address_i, timer_pkg::OFS_MOD))
      rd_mux = {16'h0, mod_reg};
    for (int n = 0; n < N; n++)
    begin
      if (hit(ch_ofs[n], timer_pkg::OFS_CH_SC))
        rd_mux = {24'h0, sc_reg[n]};
      else if (hit(ch_ofs[n], timer_pkg::OFS_CH_VH))
        rd_mux = {24'h0, (!debug_active_i && rstate_reg[n] == 2'h2) ?    // [RULE10]
                         rbuf_reg[n] : val_reg[n][15:8]};
      else if (hit(ch_ofs[n], timer_pkg::OFS_CH_VL))
        rd_mux = {24'h0, (!debug_active_i && rstate_reg[n] == 2'h1) ?    // [RULE7]
                         rbuf_reg[n] : val_reg[n][7:0]};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      wait_reg <= 1'b1;
    else
      wait_reg <= !((read_i || write_i) && wait_reg);
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      rdata_reg <= 32'h0000_0000;
    else if (rd_go)
      rdata_reg <= rd_mux;
  end

  assign readdata_o    = rdata_reg;
  assign waitrequest_o = wait_reg;
  assign ch_pin_o      = pin_reg;
  assign ch_pin_oe_o   = oe_reg;

endmodule : timer_channel_capture_pwm

// ### timer_pkg.sv
package timer_pkg;

  // ---------------------------------------------------------------------------
  // Structure
  // ---------------------------------------------------------------------------
  localparam int          NUM_CH       = 2;
  localparam int          ADDR_W       = 8;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  OFS_TSC      = 8'h00;  // timer_status_control
  localparam logic [7:0]  OFS_CNT      = 8'h04;  // counter_value
  localparam logic [7:0]  OFS_MOD      = 8'h08;  // counter_modulo
  localparam logic [7:0]  OFS_CH_BASE  = 8'h10;  // first channel block
  localparam logic [7:0]  CH_STRIDE    = 8'h10;
  localparam logic [7:0]  OFS_CH_SC    = 8'h00;  // channel_status_control
  localparam logic [7:0]  OFS_CH_VH    = 8'h04;  // channel_value_high
  localparam logic [7:0]  OFS_CH_VL    = 8'h08;  // channel_value_low

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int          TSC_PS_LSB   = 0;      // prescale, 3 bits
  localparam int          TSC_CS_LSB   = 3;      // clock_source_select, 2 bits
  localparam int          TSC_CENTER_ALIGNED_PWM_BIT = 5;      // center_pwm_select
  localparam int          SC_ELS_LSB   = 2;      // edge_level_select, 2 bits
  localparam int          SC_MS_LSB    = 4;      // channel_mode_select, 2 bits
  localparam int          SC_IE_BIT    = 6;
  localparam int          SC_FLAG_BIT  = 7;      // channel_event_flag

  // ---------------------------------------------------------------------------
  // Encodings and reset values
  // ---------------------------------------------------------------------------
  localparam logic [1:0]  CS_OFF       = 2'h0;
  localparam logic [1:0]  CS_BUS       = 2'h1;
  localparam logic [1:0]  CS_FIXED     = 2'h2;
  localparam logic [1:0]  CS_EXT       = 2'h3;
  localparam logic [1:0]  ELS_OFF      = 2'h0;
  localparam logic [15:0] CNT_FREE_TOP = 16'hFFFF;
  localparam logic [15:0] VAL_RESET    = 16'h0000;
  localparam logic [7:0]  TSC_RESET    = 8'h00;
  localparam logic [7:0]  SC_RESET     = 8'h00;

  typedef enum {M_CAPTURE, M_COMPARE, M_EDGE_ALIGNED_PWM, M_CENTER_ALIGNED_PWM} ch_mode_type;

endpackage : timer_pkg

// ### pin_partner.sv
`timescale 1ns/1ps
// --------------------
// Outside pin wiring
// --------------------
// Where the timer drives a pin, its level wins. Elsewhere the outside source sets the wire,
// so a released pin never shows the timer's last level by accident.
module pin_partner (
  input  wire logic [timer_pkg::NUM_CH-1:0] level_i,     // level applied from outside
  input  wire logic [timer_pkg::NUM_CH-1:0] drive_i,     // timer output level
  input  wire logic [timer_pkg::NUM_CH-1:0] drive_en_i,  // timer drive enable
  output logic      [timer_pkg::NUM_CH-1:0] wire_o       // resolved pin level
);
  assign wire_o = (drive_en_i & drive_i) | (~drive_en_i & level_i);
endmodule : pin_partner

// ### timer_channel_capture_pwm_sva.sv
`timescale 1ns/1ps
module timer_channel_capture_pwm_sva (
  input wire logic                              clk_i,          // clock
  input wire logic                              nrst_i,         // reset, low
  input wire logic [timer_pkg::ADDR_W-1:0]      address_i,      // address
  input wire logic                              read_i,         // read
  input wire logic                              write_i,        // write
  input wire logic [31:0]                       writedata_i,    // write data
  input wire logic [3:0]                        byteenable_i,   // lanes
  input wire logic [31:0]                       readdata_o,     // read data
  input wire logic                              waitrequest_o,  // stall
  input wire logic [timer_pkg::NUM_CH-1:0]      ch_pin_o,       // pin level
  input wire logic [timer_pkg::NUM_CH-1:0]      ch_pin_oe_o     // pin enable
);
  // --------------------
  // Shadow of channel 0 setup
  // --------------------
  logic [3:0] cfg_reg;
  logic [2:0] tsc_reg;
  logic       act_reg;
  logic       act;
  logic       take_w;
  assign take_w = write_i && waitrequest_o && byteenable_i[0];
  assign act    = (cfg_reg[1:0] != 2'h0) && (tsc_reg[2] || cfg_reg[3:2] != 2'h0);
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      cfg_reg <= 4'h0;
      tsc_reg <= 3'h0;
      act_reg <= 1'h0;
    end
    else
    begin
      act_reg <= act;
      if (take_w && address_i == 8'h10)
        cfg_reg <= writedata_i[5:2];
      if (take_w && address_i == 8'h00)
        tsc_reg <= writedata_i[5:3];
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  a_answer_next: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("access not answered in one cycle");
  a_answer_once: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("wait low for more than one cycle");
  a_idle_stall: assert property (!read_i && !write_i |=> waitrequest_o)
    else $error("answer without request");
  a_rdata_hold: assert property (!(read_i && waitrequest_o) |=> $stable(readdata_o))
    else $error("read data moved without a read");
  a_reset_quiet: assert property ($rose(nrst_i) |-> waitrequest_o && ch_pin_oe_o == 2'h0)
    else $error("outputs active after reset");
  a_pin_drive: assert property (act && act_reg |-> ch_pin_oe_o[0])
    else $error("output mode pin not driven");
  a_pin_release: assert property (!act && !act_reg |-> !ch_pin_oe_o[0])
    else $error("released pin still driven");
  a_stop_still: assert property (tsc_reg[1:0] == 2'h0 && !write_i && !$past(write_i)
    && !$past(write_i, 2) |=> $stable(ch_pin_o))
    else $error("pin moved with clock stopped");
  c_read: cover property (read_i && !waitrequest_o);
  c_write: cover property (write_i && !waitrequest_o);
  c_drive: cover property (ch_pin_oe_o[0] && ch_pin_o[0]);
endmodule : timer_channel_capture_pwm_sva

bind timer_channel_capture_pwm timer_channel_capture_pwm_sva u_sva (
  .clk_i(clk_i), .nrst_i(nrst_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
  .writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
  .waitrequest_o(waitrequest_o), .ch_pin_o(ch_pin_o), .ch_pin_oe_o(ch_pin_oe_o));

// ### timer_channel_capture_pwm_test.sv
`timescale 1ns/1ps
module timer_channel_capture_pwm_test;
  logic        clk_i, waitrequest_o;
  logic        nrst_i = 1'h0, read_i = 1'h0, write_i = 1'h0, debug_active_i = 1'h0;
  logic [7:0]  address_i = 8'h00, lo;
  logic [31:0] writedata_i = 32'h0, readdata_o, rd;
  logic [1:0]  ch_pin_i, ch_pin_o, ch_pin_oe_o, level = 2'h0;
  logic [15:0] c;
  logic [1:0]  els [3] = '{2'h3, 2'h2, 2'h1};
  logic [7:0]  pw_tsc [4] = '{8'h08, 8'h08, 8'h28, 8'h28};
  logic [7:0]  pw_sc [4] = '{8'h28, 8'h24, 8'h08, 8'h04};
  int          pw_n [4] = '{60, 180, 56, 184};
  int          err_total = 0, checked = 0, cyc = 0, n;
  timer_channel_capture_pwm u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'hF),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .debug_active_i(debug_active_i),
    .fixed_tick_i(1'h0), .ch_pin_i(ch_pin_i), .ch_pin_o(ch_pin_o), .ch_pin_oe_o(ch_pin_oe_o));
  pin_partner u_pins (.level_i(level), .drive_i(ch_pin_o), .drive_en_i(ch_pin_oe_o),
    .wire_o(ch_pin_i));
  initial
  begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_total++;
      results();
    end
  end
  task automatic results;
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    address_i   <= a;
    writedata_i <= {16'h0000, d};
    write_i     <= w;
    read_i      <= ~w;
    @(posedge clk_i);
    while (waitrequest_o !== 1'h0)
      @(posedge clk_i);
    rd = readdata_o;
    write_i <= 1'h0;
    read_i  <= 1'h0;
    @(posedge clk_i);
  endtask : bus
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rc(input string nm, input logic [7:0] a, input logic [15:0] e);
    bus(1'h0, a, 16'h0000);
    chk(nm, e, rd[15:0]);
  endtask : rc
  // Runs the counter briefly, stops it, then makes a rising edge on pin 0 at a known count.
  task automatic cap;
    bus(1'h1, 8'h00, 16'h0008);
    bus(1'h1, 8'h00, 16'h0000);
    bus(1'h0, 8'h04, 16'h0000);
    c = rd[15:0];
    level[0] <= 1'h0;
    repeat (4) @(posedge clk_i);
    level[0] <= 1'h1;
    repeat (8) @(posedge clk_i);
  endtask : cap
  task automatic pin_is(input string nm, input logic e);
    n = 0;
    while (ch_pin_o[1] !== e && n < 200) @(posedge clk_i) n++;
    chk(nm, {15'h0000, e}, {15'h0000, ch_pin_o[1]});
  endtask : pin_is
  initial
  begin
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'h1;
    @(posedge clk_i);
    rc("timer ctl", 8'h00, 16'h0000);
    rc("ch0 high", 8'h14, 16'h0000);
    rc("ch0 low", 8'h18, 16'h0000);
    bus(1'h1, 8'h10, 16'h0004);
    cap();
    rc("capture high", 8'h14, {8'h00, c[15:8]});
    rc("capture low", 8'h18, {8'h00, c[7:0]});
    rc("ch0 ctl flag", 8'h10, 16'h0084);
    rc("stopped count", 8'h04, c);
    bus(1'h1, 8'h14, 16'h0077);
    rc("read only high", 8'h14, {8'h00, c[15:8]});
    lo = c[7:0];
    cap();
    debug_active_i <= 1'h1;
    rc("debug live low", 8'h18, {8'h00, c[7:0]});
    debug_active_i <= 1'h0;
    rc("latched low", 8'h18, {8'h00, lo});
    rc("ch0 high", 8'h14, {8'h00, c[15:8]});
    cap();
    bus(1'h1, 8'h10, 16'h0004);
    rc("unlatched low", 8'h18, {8'h00, c[7:0]});
    bus(1'h1, 8'h20, 16'h0014);
    bus(1'h1, 8'h24, 16'h00AB);
    rc("half written", 8'h24, 16'h0000);
    bus(1'h1, 8'h28, 16'h00CD);
    rc("pair written", 8'h24, 16'h00AB);
    bus(1'h1, 8'h24, 16'h0000);
    debug_active_i <= 1'h1;
    bus(1'h1, 8'h28, 16'h0011);
    rc("debug write", 8'h28, 16'h0011);
    debug_active_i <= 1'h0;
    rc("pending high", 8'h24, 16'h00AB);
    bus(1'h1, 8'h28, 16'h0020);
    rc("resumed high", 8'h24, 16'h0000);
    rc("resumed low", 8'h28, 16'h0020);
    bus(1'h1, 8'h00, 16'h0008);
    for (int k = 0; k < 3; k++)
    begin
      bus(1'h1, 8'h20, {10'h000, 2'h1, els[k], 2'h0});
      bus(1'h1, 8'h04, 16'h0000);
      pin_is("compare pin", (k != 1));
      chk("compare drive", 16'h0001, {15'h0000, ch_pin_oe_o[1]});
    end
    bus(1'h1, 8'h00, 16'h0000);
    bus(1'h1, 8'h08, 16'h000F);
    bus(1'h1, 8'h20, 16'h0028);
    bus(1'h1, 8'h24, 16'h0000);
    bus(1'h1, 8'h28, 16'h0004);
    for (int k = 0; k < 4; k++)
    begin
      bus(1'h1, 8'h00, {8'h00, pw_tsc[k]});
      bus(1'h1, 8'h20, {8'h00, pw_sc[k]});
      bus(1'h1, 8'h04, 16'h0000);
      repeat (40) @(posedge clk_i);
      n = 0;
      repeat (240) @(posedge clk_i) n += ch_pin_o[1];
      chk("pwm high cycles", pw_n[k][15:0], n[15:0]);
    end
    results();
  end
endmodule : timer_channel_capture_pwm_test
